// ==== cbb_bias_ctrl.sv ====
`default_nettype none
// Operation
// - Four-state bus bias machine
// - Battery undervoltage forces off, bus floating
// - Battery recovered: off to autonomous inactive
// - Autonomous inactive biases bus to ground
// - Remote wake in low power: autonomous active
// - Silence expiry in low power drops autonomous active to inactive
// - Leaving active picks state by silence time
// - Supply undervoltage in active: autonomous active
// - Active mode request under undervoltage: autonomous active
// - Active entered only in normal, supplies good
// - Normal runs active, silent only holds active once entered, half-supply bias
// - Transmit low leaving standby blocks driver, receiver
// - Transmit low drives dominant in normal only; dominant gives receive low
// - Transmit high recessive, driver off, receive high
// - Standby receive high, low while wake pending
// - Sleep modes keep only wake receiver
// - Wake detection off in normal, silent
// - Any dominant driver makes bus dominant
module cbb_bias_ctrl
  import cbb_pkg::*;
#(
  parameter int SILENCE_CYC = SILENCE_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Supply monitors
  input  wire logic        battery_uv_falling,
  input  wire logic        battery_uv_rising,
  input  wire logic        xcvr_supply_uv_falling,
  input  wire logic        xcvr_supply_uv_rising,
  input  wire logic        io_supply_uv_falling,
  input  wire logic        io_supply_uv_rising,
  // Controller and bus side
  input  wire logic        txd,
  input  wire logic        bus_dominant,
  input  wire logic        remote_wake_pattern,
  output logic             rxd,
  output logic             canh_out,
  output logic             canh_oe_n,
  output logic             canl_out,
  output logic             canl_oe_n,
  // Bias and receiver controls
  output logic [1:0]       bias_state,
  output logic             main_rx_en,
  output logic             wake_rx_en,
  output logic             wake_det_en,
  output logic             transmit_stuck_low
);

  function automatic logic is_run_mode(input cbb_mode_t m);
    return (m == MODE_NORMAL) || (m == MODE_SILENT);
  endfunction

  function automatic logic is_low_power(input cbb_mode_t m);
    return (m == MODE_STANDBY) || (m == MODE_GTS) || (m == MODE_SLEEP);
  endfunction

  logic [SYN_N-1:0] syn_a_reg;
  logic [SYN_N-1:0] syn_b_reg;
  logic [SYN_N-1:0] syn_c_reg;
  logic [SYN_N-1:0] syn_reg;
  logic             dom_q_reg;
  logic             wk_q_reg;
  cbb_mode_t        mode_reg;
  cbb_mode_t        mode_q_reg;
  cbb_bias_t        state_reg;
  cbb_bias_t        state_next;
  logic [31:0]      sil_cnt_reg;
  logic             sil_exp_reg;
  logic             stuck_reg;
  logic             wake_pend_reg;
  logic             aw_hold_reg;
  logic             w_hold_reg;
  logic [7:0]       awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;

  logic bf;
  logic br;
  logic sup_fault;
  logic sup_good;
  logic txd_low;
  logic bus_edge;
  logic wake_evt;
  logic run_mode;
  logic low_pwr;
  logic drive_dom;
  logic rx_live;
  logic wr_go;
  logic wr_ok;
  logic [31:0] rd_val;

  // Three stages; a change is taken only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYN_N; gi++) begin : g_syn
      always_ff @(posedge core_clk) begin
        if (srst) begin
          syn_a_reg[gi] <= SYN_RST[gi];
          syn_b_reg[gi] <= SYN_RST[gi];
          syn_c_reg[gi] <= SYN_RST[gi];
          syn_reg[gi]   <= SYN_RST[gi];
        end else begin
          syn_a_reg[gi] <= (gi == SYN_DOM) ? bus_dominant :
                           (gi == SYN_TXD) ? txd :
                           (gi == SYN_WK)  ? remote_wake_pattern :
                           (gi == SYN_BF)  ? battery_uv_falling :
                           (gi == SYN_BR)  ? battery_uv_rising :
                           (gi == SYN_CF)  ? xcvr_supply_uv_falling :
                           (gi == SYN_CR)  ? xcvr_supply_uv_rising :
                           (gi == SYN_IF)  ? io_supply_uv_falling :
                                             io_supply_uv_rising;
          syn_b_reg[gi] <= syn_a_reg[gi];
          syn_c_reg[gi] <= syn_b_reg[gi];
          if (syn_b_reg[gi] == syn_c_reg[gi]) begin
            syn_reg[gi] <= syn_c_reg[gi];
          end
        end
      end
    end
  endgenerate

  assign bf        = syn_reg[SYN_BF];
  assign br        = syn_reg[SYN_BR];
  assign sup_fault = syn_reg[SYN_CF] | syn_reg[SYN_IF];
  assign sup_good  = syn_reg[SYN_CR] & syn_reg[SYN_IR] & ~sup_fault;
  assign txd_low   = ~syn_reg[SYN_TXD];
  assign run_mode  = is_run_mode(mode_reg);
  assign low_pwr   = is_low_power(mode_reg);
  assign bus_edge  = syn_reg[SYN_DOM] ^ dom_q_reg;
  assign wake_evt  = syn_reg[SYN_WK] & ~wk_q_reg & ~run_mode;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dom_q_reg  <= 1'b0;
      wk_q_reg   <= 1'b0;
      mode_q_reg <= MODE_RST;
    end else begin
      dom_q_reg  <= syn_reg[SYN_DOM];
      wk_q_reg   <= syn_reg[SYN_WK];
      mode_q_reg <= mode_reg;
    end
  end

  // Silence timer saturates so a long idle bus never wraps to activity
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sil_cnt_reg <= 32'h0;
      sil_exp_reg <= 1'b0;
    end else if (bus_edge) begin
      sil_cnt_reg <= 32'h0;
      sil_exp_reg <= 1'b0;
    end else if (sil_cnt_reg < 32'(SILENCE_CYC)) begin
      sil_cnt_reg <= sil_cnt_reg + 32'h1;
      sil_exp_reg <= (sil_cnt_reg == 32'(SILENCE_CYC - 1));
    end
  end

  always_comb begin
    state_next = state_reg;
    if (bf) begin
      state_next = CBB_OFF;
    end else begin
      case (state_reg)
        CBB_OFF: begin
          if (br) state_next = CBB_AUTO_INACT;
        end
        CBB_AUTO_INACT: begin
          if (mode_reg == MODE_NORMAL && sup_good) begin
            state_next = CBB_ACTIVE;
          end else if (wake_evt && low_pwr) begin
            state_next = CBB_AUTO_ACT;
          end else if (run_mode && sup_fault) begin
            state_next = CBB_AUTO_ACT;
          end
        end
        CBB_AUTO_ACT: begin
          if (mode_reg == MODE_NORMAL && sup_good) begin
            state_next = CBB_ACTIVE;
          end else if (low_pwr && sil_exp_reg) begin
            state_next = CBB_AUTO_INACT;
          end
        end
        CBB_ACTIVE: begin
          if (sup_fault) begin
            state_next = CBB_AUTO_ACT;
          end else if (low_pwr) begin
            state_next = sil_exp_reg ? CBB_AUTO_INACT : CBB_AUTO_ACT;
          end
        end
        default: state_next = CBB_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) state_reg <= BIAS_RST;
    else      state_reg <= state_next;
  end

  // Stuck-low latch clears once the controller releases transmit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stuck_reg <= 1'b0;
    end else if (mode_q_reg == MODE_STANDBY && mode_reg != MODE_STANDBY && txd_low) begin
      stuck_reg <= 1'b1;
    end else if (!txd_low) begin
      stuck_reg <= 1'b0;
    end
  end

  // Set wins over the clear by normal mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_pend_reg <= 1'b0;
    end else if (wake_evt) begin
      wake_pend_reg <= 1'b1;
    end else if (mode_reg == MODE_NORMAL) begin
      wake_pend_reg <= 1'b0;
    end
  end

  assign drive_dom = (state_reg == CBB_ACTIVE) && (mode_reg == MODE_NORMAL) &&
                     txd_low && !stuck_reg;
  assign rx_live   = (state_reg == CBB_ACTIVE) && run_mode && !stuck_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rxd                <= 1'b1;
      canh_out           <= 1'b0;
      canl_out           <= 1'b0;
      canh_oe_n          <= 1'b1;
      canl_oe_n          <= 1'b1;
      bias_state         <= BIAS_RST;
      main_rx_en         <= 1'b0;
      wake_rx_en         <= 1'b0;
      wake_det_en        <= 1'b0;
      transmit_stuck_low <= 1'b0;
    end else begin
      canh_out  <= 1'b1;
      canl_out  <= 1'b0;
      canh_oe_n <= ~drive_dom;
      canl_oe_n <= ~drive_dom;
      if (rx_live) begin
        rxd <= ~(syn_reg[SYN_DOM] | drive_dom);
      end else if (mode_reg == MODE_STANDBY) begin
        rxd <= ~wake_pend_reg;
      end else begin
        rxd <= 1'b1;
      end
      bias_state         <= state_reg;
      main_rx_en         <= rx_live;
      wake_rx_en         <= low_pwr;
      wake_det_en        <= ~run_mode;
      transmit_stuck_low <= stuck_reg;
    end
  end

  // AXI4-Lite slave: address and data captured in either order
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_hold_reg && w_hold_reg;
  assign wr_ok = (awaddr_reg == ADDR_CTRL) || (awaddr_reg == ADDR_STAT);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Unknown mode codes are dropped so the machine never sees them
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_reg <= MODE_RST;
    end else if (wr_go && awaddr_reg == ADDR_CTRL && wstrb_reg[0] &&
                 wdata_reg[CTRL_MODE_LSB+:3] <= 3'(MODE_SLEEP)) begin
      mode_reg <= cbb_mode_t'(wdata_reg[CTRL_MODE_LSB+:3]);
    end
  end

  always_comb begin
    rd_val = 32'h0;
    if (s_axi_araddr == ADDR_CTRL) begin
      rd_val[CTRL_MODE_LSB+:3] = mode_reg;
    end else begin
      rd_val[STAT_BIAS_LSB+:2] = state_reg;
      rd_val[STAT_SIL_BIT]     = sil_exp_reg;
      rd_val[STAT_STK_BIT]     = stuck_reg;
      rd_val[STAT_WAKE_BIT]    = wake_pend_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == ADDR_CTRL || s_axi_araddr == ADDR_STAT) begin
        s_axi_rdata <= rd_val;
        s_axi_rresp <= RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_uv_forces_off: assert property (bf |=> state_reg == CBB_OFF)
    else $error("battery undervoltage did not force off");
  a_off_exit: assert property (
    state_reg == CBB_OFF && !bf && br |=> state_reg == CBB_AUTO_INACT)
    else $error("off state not left on battery recovery");
  a_wake_to_act: assert property (
    state_reg == CBB_AUTO_INACT && !bf && wake_evt && low_pwr &&
    !(mode_reg == MODE_NORMAL) |=> state_reg == CBB_AUTO_ACT)
    else $error("remote wake did not raise bias");
  a_silence_drop: assert property (
    state_reg == CBB_AUTO_ACT && !bf && low_pwr && sil_exp_reg
    |=> state_reg == CBB_AUTO_INACT)
    else $error("silence expiry did not drop bias");
  a_leave_active: assert property (
    state_reg == CBB_ACTIVE && !bf && !sup_fault && low_pwr
    |=> state_reg == ($past(sil_exp_reg) ? CBB_AUTO_INACT : CBB_AUTO_ACT))
    else $error("wrong state on leaving active");
  a_fault_to_auto: assert property (
    state_reg == CBB_ACTIVE && !bf && sup_fault |=> state_reg == CBB_AUTO_ACT)
    else $error("supply fault did not leave active");
  a_active_entry: assert property (
    state_reg != CBB_ACTIVE ##1 state_reg == CBB_ACTIVE
    |-> $past(mode_reg == MODE_NORMAL && sup_good))
    else $error("active entered without normal and good supplies");
  a_drive_dominant: assert property (
    drive_dom |=> !canh_oe_n && !canl_oe_n && !rxd)
    else $error("dominant not driven for low transmit");
  a_stuck_block: assert property (
    stuck_reg |=> canh_oe_n && canl_oe_n && !main_rx_en)
    else $error("stuck transmit not blocked");
  a_standby_rxd: assert property (
    mode_reg == MODE_STANDBY && state_reg != CBB_ACTIVE
    |=> rxd == !$past(wake_pend_reg))
    else $error("standby receive output wrong");
  a_timer_restart: assert property (
    bus_edge |=> sil_cnt_reg == 32'h0 && !sil_exp_reg)
    else $error("silence timer not restarted");
  a_wake_gated: assert property (run_mode |=> !wake_det_en)
    else $error("wake detection active in run mode");

endmodule
`default_nettype wire

// ==== cbb_bus_model.sv ====
`default_nettype none
module cbb_bus_model #(
  parameter int FILT = 4,
  parameter int TMO  = 64
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Driver enables of the design
  input  wire logic canh_oe_n,
  input  wire logic canl_oe_n,
  // Other nodes and wake detector
  input  wire logic other_dom,
  output logic      bus_dominant,
  output logic      remote_wake_pattern
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase_reg;
  logic [7:0] run_reg;
  logic [7:0] age_reg;
  logic       last_reg;
  logic       filt;
  // Any dominant driver wins over recessive
  assign bus_dominant = !canh_oe_n || !canl_oe_n || other_dom;
  assign filt = run_reg >= 8'(FILT);
  // Run length saturates at the filter time
  always_ff @(posedge core_clk) begin
    if (srst) begin
      last_reg <= 1'b0;
      run_reg  <= 8'h00;
    end else begin
      last_reg <= bus_dominant;
      run_reg  <= (bus_dominant != last_reg) ? 8'h00 : (filt ? run_reg : run_reg + 8'h01);
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst || age_reg == 8'(TMO)) begin
      phase_reg           <= 2'h0;
      age_reg             <= 8'h00;
      remote_wake_pattern <= 1'b0;
    end else begin
      age_reg <= (phase_reg == 2'h1 || phase_reg == 2'h2) ? age_reg + 8'h01 : 8'h00;
      case (phase_reg)
        2'h0: if (filt && last_reg) phase_reg <= 2'h1;
        2'h1: if (filt && !last_reg) phase_reg <= 2'h2;
        2'h2: if (filt && last_reg) begin
          phase_reg           <= 2'h3;
          remote_wake_pattern <= 1'b1;
        end
        default: if (!bus_dominant) begin
          phase_reg           <= 2'h0;
          remote_wake_pattern <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== cbb_pkg.sv ====
`default_nettype none
package cbb_pkg;
  typedef enum logic [1:0] {
    CBB_OFF        = 2'h0,
    CBB_AUTO_INACT = 2'h1,
    CBB_AUTO_ACT   = 2'h2,
    CBB_ACTIVE     = 2'h3
  } cbb_bias_t;
  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'h0,
    MODE_SILENT  = 3'h1,
    MODE_STANDBY = 3'h2,
    MODE_GTS     = 3'h3,
    MODE_SLEEP   = 3'h4
  } cbb_mode_t;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int CTRL_MODE_LSB = 0;
  localparam int STAT_BIAS_LSB = 0;
  localparam int STAT_SIL_BIT  = 2;
  localparam int STAT_STK_BIT  = 3;
  localparam int STAT_WAKE_BIT = 4;
  localparam cbb_mode_t MODE_RST = MODE_STANDBY;
  localparam cbb_bias_t BIAS_RST = CBB_OFF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pin synchroniser lanes
  localparam int SYN_N   = 9;
  localparam int SYN_BF  = 0;
  localparam int SYN_BR  = 1;
  localparam int SYN_CF  = 2;
  localparam int SYN_CR  = 3;
  localparam int SYN_IF  = 4;
  localparam int SYN_IR  = 5;
  localparam int SYN_TXD = 6;
  localparam int SYN_DOM = 7;
  localparam int SYN_WK  = 8;
  localparam logic [8:0] SYN_RST = 9'h040;
  localparam int CLK_PERIOD_NS       = 8;
  localparam int BUS_SILENCE_TIME_US = 1000;
  localparam int SILENCE_CYCLES = (BUS_SILENCE_TIME_US * 1000) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top
  import cbb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp, bias_state;
  logic        bf, br, cf, cr, iof, ior, txd, other_dom, bus_dom, wake;
  logic        rxd, ch, choe, cl, cloe, mrx, wrx, wde, stk;
  int          mismatches, n_tests;
  // Short silence time keeps the run brief
  cbb_bias_ctrl #(.SILENCE_CYC(40)) dut (
    .core_clk(core_clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .battery_uv_falling(bf), .battery_uv_rising(br),
    .xcvr_supply_uv_falling(cf), .xcvr_supply_uv_rising(cr),
    .io_supply_uv_falling(iof), .io_supply_uv_rising(ior),
    .txd(txd), .bus_dominant(bus_dom), .remote_wake_pattern(wake),
    .rxd(rxd), .canh_out(ch), .canh_oe_n(choe), .canl_out(cl), .canl_oe_n(cloe),
    .bias_state(bias_state), .main_rx_en(mrx), .wake_rx_en(wrx),
    .wake_det_en(wde), .transmit_stuck_low(stk)
  );
  cbb_bus_model bus (
    .core_clk(core_clk), .srst(srst), .canh_oe_n(choe), .canl_oe_n(cloe),
    .other_dom(other_dom), .bus_dominant(bus_dom), .remote_wake_pattern(wake)
  );
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge core_clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    // One idle edge so the next call never re-raises a strobe in this step
    @(posedge core_clk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask
  // Dominant, recessive, dominant, each past the filter time
  task automatic wake_seq;
    other_dom <= 1'b1;
    settle(7);
    other_dom <= 1'b0;
    settle(7);
    other_dom <= 1'b1;
    settle(10);
    other_dom <= 1'b0;
    settle(4);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    settle(20000);
    mismatches++;
    final_report();
  end
  initial begin
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0000_0000, 4'hF};
    {bf, br, cf, cr, iof, ior, txd, other_dom} = 8'h02;
    mismatches = 0;
    n_tests = 0;
    settle(2);
    srst <= 1'b0;
    settle(1);
    `CHK({bias_state, choe, cloe, rxd}, {CBB_OFF, 3'b111});
    rd_reg(ADDR_CTRL);
    `CHK(rd, 32'(MODE_STANDBY));
    rd_reg(8'h08);
    `CHK(rsp, RESP_SLVERR);
    `CHK(rd, 32'h0);
    wr(8'h10, 32'h1);
    `CHK(rsp, RESP_SLVERR);
    wr(ADDR_CTRL, 32'h7);
    rd_reg(ADDR_CTRL);
    `CHK(rd, 32'(MODE_STANDBY));
    br <= 1'b1;
    settle(8);
    `CHK(bias_state, CBB_AUTO_INACT);
    wake_seq();
    `CHK({bias_state, rxd, wrx, mrx}, {CBB_AUTO_ACT, 3'b010});
    settle(50);
    `CHK({bias_state, rxd}, {CBB_AUTO_INACT, 1'b0});
    cr <= 1'b1;
    ior <= 1'b1;
    wr(ADDR_CTRL, 32'(MODE_NORMAL));
    settle(8);
    `CHK({bias_state, mrx, wde, wrx, rxd}, {CBB_ACTIVE, 4'b1001});
    txd <= 1'b0;
    settle(6);
    `CHK({choe, cloe, ch, cl, rxd}, 5'b00100);
    txd <= 1'b1;
    // Own dominant echo must clear the pin filter before receive goes high
    settle(12);
    `CHK({choe, cloe, rxd}, 3'b111);
    other_dom <= 1'b1;
    settle(6);
    `CHK({choe, rxd}, 2'b10);
    other_dom <= 1'b0;
    settle(8);
    wake_seq();
    rd_reg(ADDR_STAT);
    `CHK(rd[STAT_WAKE_BIT], 1'b0);
    cf <= 1'b1;
    cr <= 1'b0;
    settle(8);
    `CHK(bias_state, CBB_AUTO_ACT);
    cf <= 1'b0;
    cr <= 1'b1;
    settle(8);
    `CHK(bias_state, CBB_ACTIVE);
    txd <= 1'b0;
    settle(6);
    txd <= 1'b1;
    settle(6);
    wr(ADDR_CTRL, 32'(MODE_STANDBY));
    settle(6);
    `CHK(bias_state, CBB_AUTO_ACT);
    settle(50);
    rd_reg(ADDR_STAT);
    `CHK(rd[4:0], {3'b001, CBB_AUTO_INACT});
    wr(ADDR_CTRL, 32'(MODE_NORMAL));
    settle(50);
    wr(ADDR_CTRL, 32'(MODE_SLEEP));
    settle(6);
    `CHK(bias_state, CBB_AUTO_INACT);
    `CHK({mrx, wrx, rxd, choe}, 4'b0111);
    wr(ADDR_CTRL, 32'(MODE_GTS));
    settle(6);
    `CHK({bias_state, mrx, wrx, rxd}, {CBB_AUTO_INACT, 3'b011});
    iof <= 1'b1;
    ior <= 1'b0;
    settle(6);
    wr(ADDR_CTRL, 32'(MODE_SILENT));
    settle(6);
    `CHK(bias_state, CBB_AUTO_ACT);
    iof <= 1'b0;
    ior <= 1'b1;
    wr(ADDR_CTRL, 32'(MODE_NORMAL));
    settle(8);
    wr(ADDR_CTRL, 32'(MODE_SILENT));
    txd <= 1'b0;
    settle(8);
    `CHK({bias_state, choe}, {CBB_ACTIVE, 1'b1});
    // Silent mode never clears a pending wake, so a leak would show here
    wake_seq();
    rd_reg(ADDR_STAT);
    `CHK(rd[STAT_WAKE_BIT], 1'b0);
    wr(ADDR_CTRL, 32'(MODE_STANDBY));
    settle(6);
    wr(ADDR_CTRL, 32'(MODE_NORMAL));
    settle(8);
    `CHK({bias_state, stk, choe, rxd}, {CBB_ACTIVE, 3'b111});
    txd <= 1'b1;
    settle(8);
    `CHK(stk, 1'b0);
    bf <= 1'b1;
    settle(8);
    `CHK({bias_state, choe, cloe}, {CBB_OFF, 2'b11});
    final_report();
  end
endmodule
`default_nettype wire
